// file: logic/sbc_ctrl.sv
`default_nettype none
module sbc_ctrl
   import sbc_pkg::*;
(
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic               ce,
   input  wire logic [sbc_pkg::AW-1:0] awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   input  wire logic [sbc_pkg::AW-1:0] araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   input  wire logic               link_clk,
   input  wire logic               scl_in,
   output logic                    scl_out,
   output logic                    scl_oe,
   input  wire logic               sda_in,
   output logic                    sda_out,
   output logic                    sda_oe,
   input  wire logic [7:0]         addr_byte,
   input  wire logic               busy_req,
   output logic                    addr_match,
   output logic                    wait_release,
   output logic [1:0]              wait_mode,
   output logic                    irq_on_release,
   output logic                    serial_run_enable,
   output logic [1:0]              protocol_select
);
   import sbc_pkg::*;

   // ---------------- link domain ----------------
   logic       l_rn1, l_rn2;
   logic       l_sda1, l_sda2, l_sda3, l_scl1, l_scl2, l_scl3;
   logic [3:0] l_cnt, next_l_cnt;
   logic       l_cmd, next_l_cmd, l_rel, next_l_rel;
   logic       l_ack, next_l_ack, l_slot, next_l_slot;
   logic       l_start, l_stop, l_rise;

   // reset is brought over so the link side leaves reset in step with link_clk, whatever the bus is doing
   always_ff @(posedge link_clk) begin
      l_rn1  <= aresetn;
      l_rn2  <= l_rn1;
      l_sda1 <= sda_in;
      l_sda2 <= l_sda1;
      l_sda3 <= l_sda2;
      l_scl1 <= scl_in;
      l_scl2 <= l_scl1;
      l_scl3 <= l_scl2;
   end

   assign l_start = l_scl2 & l_scl3 & l_sda3 & ~l_sda2;
   assign l_stop  = l_scl2 & l_scl3 & ~l_sda3 & l_sda2;
   assign l_rise  = l_scl2 & ~l_scl3;

   always_comb begin
      next_l_cnt = l_cnt;
      next_l_cmd = l_cmd;
      next_l_rel = l_rel;
      next_l_ack = l_ack;
      if (l_start) begin
         next_l_cnt = 4'h0;
         next_l_cmd = 1'b1; // R5
         next_l_rel = 1'b0;
      end else if (l_stop) begin
         next_l_cmd = 1'b0;
         next_l_rel = 1'b1; // R5
      end else if (l_rise) begin
         if (l_cnt == ACK_BIT) begin
            next_l_cnt = 4'h0;
            next_l_ack = ~l_sda2; // R9
         end else begin
            next_l_cnt = l_cnt + 4'h1;
         end
      end
      next_l_slot = (next_l_cnt == ACK_BIT);
   end

   always_ff @(posedge link_clk) begin
      if (!l_rn2) begin
         l_cnt  <= 4'h0;
         l_cmd  <= 1'b0;
         l_rel  <= 1'b0;
         l_ack  <= 1'b0;
         l_slot <= 1'b0;
      end else begin
         l_cnt  <= next_l_cnt;
         l_cmd  <= next_l_cmd;
         l_rel  <= next_l_rel;
         l_ack  <= next_l_ack;
         l_slot <= next_l_slot;
      end
   end

   // ---------------- system domain ----------------
   logic [4:0] s1, s2;
   logic       slot_d;
   logic       scl_sense, cmd_seen, rel_seen, ack_seen, slot_s;
   assign {scl_sense, cmd_seen, rel_seen, ack_seen, slot_s} = s2;

   logic [1:0] wmode, next_wmode, proto, next_proto;
   logic       clk_drive, next_clk_drive, wrel, next_wrel;
   logic       irq_src, next_irq_src, cmp_w, next_cmp_w;
   logic       busy_en, next_busy_en, ack_auto, next_ack_auto;
   logic       ack_hold, next_ack_hold, out_latch, next_out_latch;
   logic       run, next_run, match, next_match;
   logic       scl_oe_r, next_scl_oe, sda_oe_r, next_sda_oe;
   logic [7:0] saddr, next_saddr;

   logic            aw_hold, next_aw_hold, w_hold, next_w_hold;
   logic [AW-1:0]   aw_addr, next_aw_addr;
   logic [3:0]      w_data, next_w_data;
   logic            w_lane, next_w_lane;
   logic            bv, next_bv, rv, next_rv;
   logic [1:0]      br, next_br, rr, next_rr;
   logic [31:0]     rd, next_rd;
   logic            wr_go, wr_ok, rd_ok;
   logic [7:0]      wr_idx, rd_idx;
   logic [3:0]      rd_val;
   logic            wr_trig, wr_ack;

   assign awready = ce & ~aw_hold & ~bv;
   assign wready  = ce & ~w_hold & ~bv;
   assign arready = ce & ~rv;
   assign wr_go   = aw_hold & w_hold & ~bv;
   assign wr_idx  = aw_addr[9:2];
   assign rd_idx  = araddr[9:2];
   assign wr_ok   = (aw_addr[AW-1:10] == '0)
                    && (wr_idx >= IDX_WAIT) && (wr_idx <= IDX_SADDR);
   assign rd_ok   = (araddr[AW-1:10] == '0)
                    && (rd_idx >= IDX_WAIT) && (rd_idx <= IDX_SADDR);
   assign wr_trig = wr_go & wr_ok & w_lane & (wr_idx == IDX_TRIG);
   assign wr_ack  = wr_go & wr_ok & w_lane & (wr_idx == IDX_ACK)
                    & w_data[B_ACK_TRIG];

   // trigger bits clear themselves, so they always read back zero
   always_comb begin
      rd_val = 4'h0;
      unique case (rd_idx)
         IDX_WAIT: rd_val = {clk_drive, 1'b0, wmode};
         IDX_IRQ:  rd_val = {1'b0, scl_sense, irq_src, cmp_w}; // R3
         IDX_TRIG: rd_val = {cmd_seen, rel_seen, 2'b00}; // R5
         IDX_ACK:  rd_val = {busy_en, ack_seen, ack_auto, 1'b0}; // R9
         IDX_MODE: rd_val = {2'b00, proto};
         IDX_RUN:  rd_val = {run, 3'b000};
         default:  rd_val = 4'h0;
      endcase
   end

   always_comb begin
      next_aw_hold = aw_hold | (awvalid & awready);
      next_aw_addr = (awvalid & awready) ? awaddr : aw_addr;
      next_w_hold  = w_hold | (wvalid & wready);
      next_w_data  = (wvalid & wready) ? wdata[3:0] : w_data;
      next_w_lane  = (wvalid & wready) ? wstrb[0] : w_lane;
      next_bv = bv & ~bready;
      next_br = br;
      if (wr_go) begin
         next_aw_hold = 1'b0;
         next_w_hold  = 1'b0;
         next_bv      = 1'b1;
         next_br      = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      next_rv = rv & ~rready;
      next_rd = rd;
      next_rr = rr;
      if (arvalid & arready) begin
         next_rv = 1'b1;
         next_rr = rd_ok ? RESP_OKAY : RESP_SLVERR;
         // refused addresses return zero data along with the error
         if (!rd_ok)
            next_rd = 32'h0;
         else if (rd_idx == IDX_SADDR)
            next_rd = {24'h0, saddr};
         else
            next_rd = {28'h0, rd_val};
      end
   end

   always_comb begin
      next_clk_drive = clk_drive;
      next_wmode     = wmode;
      next_irq_src   = irq_src;
      next_cmp_w     = cmp_w;
      next_busy_en   = busy_en;
      next_ack_auto  = ack_auto;
      next_proto     = proto;
      next_run       = run;
      next_saddr     = saddr;
      next_out_latch = out_latch;
      next_wrel      = 1'b0;
      if (wr_go && wr_ok && w_lane) begin
         unique case (wr_idx)
            IDX_WAIT: begin
               next_clk_drive = w_data[B_CLK_DRIVE]; // R1
               next_wrel      = w_data[B_WAIT_REL]; // R2
               next_wmode     = w_data[1:0]; // R2
            end
            IDX_IRQ: begin
               next_irq_src = w_data[B_IRQ_SRC]; // R4
               next_cmp_w   = w_data[B_CMP_W]; // R4
            end
            IDX_ACK: begin
               next_busy_en  = w_data[B_BUSY_EN]; // R8
               next_ack_auto = w_data[B_ACK_AUTO]; // R9
            end
            IDX_MODE: next_proto = w_data[1:0]; // R11
            IDX_RUN:  next_run   = w_data[B_RUN]; // R12
            IDX_SADDR: next_saddr = {4'h0, w_data};
            default: next_run = run;
         endcase
      end
      // command trigger takes priority when both triggers are written
      if (wr_trig && w_data[B_CMD_TRIG])
         next_out_latch = 1'b0; // R6
      else if (wr_trig && w_data[B_REL_TRIG])
         next_out_latch = 1'b1; // R7
      // a new trigger wins over the end of the ack slot
      next_ack_hold = wr_ack | (ack_hold & ~(slot_d & ~slot_s)); // R10
      if (cmp_w)
         next_match = (addr_byte[7:1] == saddr[7:1]); // R4
      else
         next_match = (addr_byte == saddr); // R4
      next_scl_oe = run && (proto == PROTO_2WIRE) && !clk_drive; // R1
      next_sda_oe = run && (proto != PROTO_3WIRE) // R11 R12
                    && (!out_latch || ack_hold // R10
                        || (ack_auto && slot_s) // R9
                        || (busy_en && busy_req)); // R8
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1 <= 5'h00; s2 <= 5'h00; slot_d <= 1'b0;
         aw_hold <= 1'b0; w_hold <= 1'b0; aw_addr <= '0;
         w_data <= 4'h0; w_lane <= 1'b0;
         bv <= 1'b0; br <= RESP_OKAY;
         rv <= 1'b0; rr <= RESP_OKAY; rd <= 32'h0;
         clk_drive <= 1'b0; wrel <= 1'b0; wmode <= WAIT_RST;
         irq_src <= 1'b0; cmp_w <= 1'b0; busy_en <= 1'b0;
         ack_auto <= 1'b0; ack_hold <= 1'b0; out_latch <= 1'b1;
         proto <= PROTO_RST; run <= 1'b0; saddr <= SADDR_RST;
         match <= 1'b0; scl_oe_r <= 1'b0; sda_oe_r <= 1'b0;
      end else if (ce) begin
         s1 <= {scl_in, l_cmd, l_rel, l_ack, l_slot};
         s2 <= s1;
         slot_d <= slot_s;
         aw_hold <= next_aw_hold; w_hold <= next_w_hold;
         aw_addr <= next_aw_addr; w_data <= next_w_data;
         w_lane <= next_w_lane;
         bv <= next_bv; br <= next_br;
         rv <= next_rv; rr <= next_rr; rd <= next_rd;
         clk_drive <= next_clk_drive; wrel <= next_wrel;
         wmode <= next_wmode; irq_src <= next_irq_src;
         cmp_w <= next_cmp_w; busy_en <= next_busy_en;
         ack_auto <= next_ack_auto; ack_hold <= next_ack_hold;
         out_latch <= next_out_latch;
         proto <= next_proto; run <= next_run; saddr <= next_saddr;
         match <= next_match; scl_oe_r <= next_scl_oe;
         sda_oe_r <= next_sda_oe;
      end
   end

   // both lines are open drain: only ever pulled low
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe  = scl_oe_r;
   assign sda_oe  = sda_oe_r;
   assign bvalid  = bv;
   assign bresp   = br;
   assign rvalid  = rv;
   assign rresp   = rr;
   assign rdata   = rd;
   assign addr_match        = match;
   assign wait_release      = wrel;
   assign wait_mode         = wmode;
   assign irq_on_release    = irq_src;
   assign serial_run_enable = run;
   assign protocol_select   = proto;

   // ---------------- checks ----------------
   sequence s_ack_write;
      ce && wr_ack;
   endsequence
   sequence s_scl_high3;
      (ce && scl_in)[*3];
   endsequence

   a_cmd_trig_low: assert property (@(posedge aclk) // R6
      disable iff (!aresetn)
      ce && wr_trig && w_data[B_CMD_TRIG] |=> !out_latch)
      else $error("command trigger did not clear output latch");
   a_rel_trig_high: assert property (@(posedge aclk) // R7
      disable iff (!aresetn)
      ce && wr_trig && !w_data[B_CMD_TRIG] && w_data[B_REL_TRIG]
      |=> out_latch)
      else $error("release trigger did not set output latch");
   a_scl_hold_low: assert property (@(posedge aclk) // R1
      disable iff (!aresetn)
      ce && run && proto == PROTO_2WIRE && !clk_drive |=> scl_oe)
      else $error("clock line not pulled low");
   // a frozen clock enable holds the pulse, so only count enabled cycles
   a_wait_rel_pulse: assert property (@(posedge aclk) // R2
      disable iff (!aresetn)
      ce && wait_release |=> !wait_release)
      else $error("wait release longer than one cycle");
   a_scl_sense_sync: assert property (@(posedge aclk) // R3
      disable iff (!aresetn)
      s_scl_high3 |-> scl_sense)
      else $error("clock sense does not follow line");
   a_addr_cmp_wide: assert property (@(posedge aclk) // R4
      disable iff (!aresetn)
      ce && cmp_w && addr_byte[7:1] == saddr[7:1] |=> addr_match)
      else $error("seven-bit address compare missed");
   a_busy_drive_on: assert property (@(posedge aclk) // R8
      disable iff (!aresetn)
      ce && run && proto != PROTO_3WIRE && busy_en && busy_req |=> sda_oe)
      else $error("busy not driven");
   a_ack_trig_hold: assert property (@(posedge aclk) // R10
      disable iff (!aresetn)
      s_ack_write |=> ack_hold)
      else $error("ack trigger not taken");
   a_run_off_quiet: assert property (@(posedge aclk) // R12
      disable iff (!aresetn)
      ce && (!run || proto == PROTO_3WIRE) |=> !sda_oe && !scl_oe) // R11
      else $error("bus driven while stopped or three-wire");
   a_cmd_flag_set: assert property (@(posedge link_clk) // R5
      disable iff (!l_rn2)
      l_start |=> l_cmd && !l_rel)
      else $error("command not flagged");
   a_ack_flag_take: assert property (@(posedge link_clk) // R9
      disable iff (!l_rn2)
      !l_start && !l_stop && l_rise && l_cnt == ACK_BIT
      |=> l_ack == !$past(l_sda2))
      else $error("ack detect wrong");
endmodule
`default_nettype wire

// file: logic/sbc_pkg.sv
// Operation
// (R1) in two-wire mode software drives the clock line level from a bit
// (R2) two-bit field picks wait/irq timing; write-one bit releases a wait
// (R3) read-only bit shows clock line level; register top bit reads 0
// (R4) compare-width picks address bits 0-7 or 1-7; irq source select bit
// (R5) read-only flags show command and bus release detection on the bus
// (R6) writing command trigger clears the output latch, bit self-clears
// (R7) writing release trigger sets the output latch, bit self-clears
// (R8) busy-enable bit permits or suppresses the busy drive on the bus
// (R9) auto-ack enable makes ack automatic; flag reports partner ack seen
// (R10) writing ack trigger drives an ack at once; zero does nothing
// (R11) mode field: 0 three-wire, 1 serial-bus, 3 two-wire serial
// (R12) run-enable bit stops the whole interface when clear; here it only stops both line drives, flags still update
`default_nettype none
package sbc_pkg;
   localparam int unsigned AW = 12;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_WAIT  = 8'h0a;
   localparam logic [7:0] IDX_IRQ   = 8'h0b;
   localparam logic [7:0] IDX_TRIG  = 8'h0c;
   localparam logic [7:0] IDX_ACK   = 8'h0d;
   localparam logic [7:0] IDX_MODE  = 8'h0e;
   localparam logic [7:0] IDX_RUN   = 8'h0f;
   localparam logic [7:0] IDX_SADDR = 8'h10;
   // bit positions
   localparam int unsigned B_CLK_DRIVE = 3;
   localparam int unsigned B_WAIT_REL  = 2;
   localparam int unsigned B_SENSE     = 2;
   localparam int unsigned B_IRQ_SRC   = 1;
   localparam int unsigned B_CMP_W     = 0;
   localparam int unsigned B_CMD_SEEN  = 3;
   localparam int unsigned B_REL_SEEN  = 2;
   localparam int unsigned B_CMD_TRIG  = 1;
   localparam int unsigned B_REL_TRIG  = 0;
   localparam int unsigned B_BUSY_EN   = 3;
   localparam int unsigned B_ACK_SEEN  = 2;
   localparam int unsigned B_ACK_AUTO  = 1;
   localparam int unsigned B_ACK_TRIG  = 0;
   localparam int unsigned B_RUN       = 3;
   // reset values
   localparam logic [1:0] WAIT_RST  = 2'h0;
   localparam logic [1:0] PROTO_RST = 2'h0;
   localparam logic [7:0] SADDR_RST = 8'h00;
   // protocol codes
   localparam logic [1:0] PROTO_3WIRE = 2'h0;
   localparam logic [1:0] PROTO_SBUS  = 2'h1;
   localparam logic [1:0] PROTO_2WIRE = 2'h3;
   // wait codes usable in two-wire mode
   localparam logic [1:0] WAIT_I2C_A = 2'h2;
   localparam logic [1:0] WAIT_I2C_B = 2'h3;
   // ack slot is the ninth clock, counted from zero
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: test/sbc_bus_dev.sv
`default_nettype none
module sbc_bus_dev (
   input  wire logic link_clk,
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda
);
   timeunit 1ns;
   timeprecision 100ps;
   logic scl_low;
   logic sda_low;
   // pull-ups: a line nobody pulls low floats high
   assign scl = !(scl_low || scl_oe);
   assign sda = !(sda_low || sda_oe);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge link_clk);
   endtask
   task automatic start_cond();
      hold(1);
      sda_low <= 1'b1;
      hold(4);
      scl_low <= 1'b1;
      hold(4);
   endtask
   // data bits released; ack pulled low on the ninth pulse when asked
   // data only moves while the clock is low, so no false stop is seen
   task automatic clock_byte(input logic ack);
      hold(1);
      for (int i = 0; i < 9; i++) begin
         sda_low <= (i == 8) && ack;
         hold(4);
         scl_low <= 1'b0;
         hold(4);
         scl_low <= 1'b1;
      end
      hold(4);
   endtask
   task automatic stop_cond();
      hold(1);
      sda_low <= 1'b1;
      hold(4);
      scl_low <= 1'b0;
      hold(4);
      sda_low <= 1'b0;
      hold(4);
   endtask
endmodule
`default_nettype wire

// file: test/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import sbc_pkg::*;
   logic          aclk, aresetn, link_clk, busy_req, ce;
   logic [AW-1:0] awaddr, araddr;
   logic          awvalid, wvalid, bready, arvalid, rready;
   logic [31:0]   wdata, rdata;
   logic [3:0]    wstrb;
   logic [7:0]    addr_byte;
   logic          awready, wready, bvalid, arready, rvalid;
   logic          scl_oe, sda_oe, scl_out, sda_out, addr_match;
   logic          wait_release, irq_on_release, serial_run_enable;
   logic [1:0]    bresp, rresp, wait_mode, protocol_select;
   wire logic     scl_line, sda_line;
   int            err_total, samples_checked;
   logic [31:0]   rst_exp [7];

   sbc_ctrl dut_u (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .link_clk,
      .scl_in(scl_line), .scl_out, .scl_oe, .sda_in(sda_line), .sda_out,
      .sda_oe, .addr_byte, .busy_req, .addr_match, .wait_release,
      .wait_mode, .irq_on_release, .serial_run_enable, .protocol_select);
   sbc_bus_dev dev (.link_clk, .scl_oe, .sda_oe, .scl(scl_line),
      .sda(sda_line));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // odd offset keeps the link clock unrelated in phase to aclk
   initial begin
      link_clk = 1'b0;
      #0.4;
      forever begin
         link_clk = ~link_clk;
         #7.5;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic give_up();
      err_total++;
      report_and_stop();
   endtask
   task automatic axi_write(input logic [AW-1:0] a, input logic [31:0] d,
                            input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 50) give_up();
      chk(bresp, er);
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      axi_write(a, d, RESP_OKAY);
   endtask
   task automatic axi_read(input logic [AW-1:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n == 50) give_up();
   endtask
   task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      chk(r, RESP_OKAY);
      chk(d, e);
   endtask
   // link flags cross two domains, so poll with a bound
   task automatic poll(input logic [AW-1:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 40; i++) begin
         axi_read(a, d, r);
         if (d === e) break;
      end
      chk(d, e);
   endtask
   task automatic settle();
      repeat (3) @(posedge aclk);
   endtask

   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      err_total = 0;
      samples_checked = 0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, busy_req} = '0;
      {awaddr, araddr, wdata, addr_byte} = '0;
      wstrb = 4'hf;
      ce = 1'b1;
      rst_exp = '{32'h0, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 7; i++)
         rd_chk(12'h028 + 12'(4 * i), rst_exp[i]);
      axi_read(12'h000, d, r);
      chk(r, RESP_SLVERR);
      chk(d, 32'h0);
      axi_write(12'h044, 32'h1, RESP_SLVERR);
      wr(12'h038, 32'h3);
      wr(12'h03c, 32'h8);
      settle();
      chk(scl_oe, 1'b1);
      chk(serial_run_enable, 1'b1);
      chk(protocol_select, PROTO_2WIRE);
      chk({scl_out, sda_out}, 2'b00);
      poll(12'h02c, 32'h0);
      wr(12'h028, 32'hb);
      settle();
      chk(scl_oe, 1'b0);
      chk(wait_mode, WAIT_I2C_B);
      rd_chk(12'h028, 32'hb);
      poll(12'h02c, 32'h4);
      wr(12'h028, 32'hc);
      chk(wait_release, 1'b1);
      rd_chk(12'h028, 32'h8);
      chk(wait_mode, 2'h0);
      chk(wait_release, 1'b0);
      wr(12'h040, 32'h5);
      wstrb <= 4'he;
      wr(12'h040, 32'h0);
      wstrb <= 4'hf;
      rd_chk(12'h040, 32'h5);
      addr_byte <= 8'h04;
      wr(12'h02c, 32'h3);
      rd_chk(12'h02c, 32'h7);
      chk(irq_on_release, 1'b1);
      settle();
      chk(addr_match, 1'b1);
      wr(12'h02c, 32'h0);
      settle();
      chk(addr_match, 1'b0);
      wr(12'h030, 32'h2);
      settle();
      chk(sda_oe, 1'b1);
      // the latch drop with the clock line high is a command on the bus
      poll(12'h030, 32'h8);
      wr(12'h030, 32'h1);
      settle();
      chk(sda_oe, 1'b0);
      poll(12'h030, 32'h4);
      wr(12'h038, 32'h0);
      wr(12'h030, 32'h2);
      settle();
      chk(sda_oe, 1'b0);
      wr(12'h038, 32'h1);
      settle();
      chk(sda_oe, 1'b1);
      wr(12'h030, 32'h1);
      dev.start_cond();
      poll(12'h030, 32'h8);
      dev.clock_byte(1'b1);
      poll(12'h034, 32'h4);
      dev.stop_cond();
      poll(12'h030, 32'h4);
      wr(12'h034, 32'h8);
      busy_req <= 1'b1;
      settle();
      chk(sda_oe, 1'b1);
      wr(12'h034, 32'h0);
      settle();
      chk(sda_oe, 1'b0);
      busy_req <= 1'b0;
      wr(12'h034, 32'h1);
      settle();
      chk(sda_oe, 1'b1);
      rd_chk(12'h034, 32'h4);
      // the held ack made a start with the clock high; lower it first
      dev.start_cond();
      dev.clock_byte(1'b0);
      settle();
      chk(sda_oe, 1'b0);
      dev.clock_byte(1'b0);
      poll(12'h034, 32'h0);
      wr(12'h034, 32'h2);
      dev.clock_byte(1'b0);
      poll(12'h034, 32'h6);
      ce <= 1'b0;
      addr_byte <= 8'h05;
      settle();
      chk(addr_match, 1'b0);
      chk({awready, wready, arready}, 3'b000);
      ce <= 1'b1;
      settle();
      chk(addr_match, 1'b1);
      report_and_stop();
   end
endmodule
`default_nettype wire
